/* logic/elp_map.vh */
// Register map, field layout and reset values for the linear protection block
`ifndef ELP_MAP_VH
`define ELP_MAP_VH

// Address: [11:10] table select, rest entry and word select
`define ELP_TSEL_SVC 2'h0
`define ELP_TSEL_MISC 2'h1
`define ELP_TSEL_EGR 2'h2
`define ELP_SVC_WORD_BIT 4
`define ELP_MISC_SEL_GRP 2'h0
`define ELP_MISC_SEL_LIM 2'h1
`define ELP_MISC_SEL_CNT 2'h2
`define ELP_EGR_WORD_ACT 2'h0
`define ELP_EGR_WORD_VLAN 2'h1
`define ELP_EGR_WORD_LSE 2'h2

// Service entry word 0
`define ELP_MODE_LSB 0
`define ELP_DROP_LSB 2
`define ELP_GRP_LSB 4
`define ELP_FTYPE_LSB 8
`define ELP_FID_LSB 12
// Service entry word 1
`define ELP_MC_LSB 0

// Egress action word 0
`define ELP_ENC_LSB 0
`define ELP_BENC_LSB 8
`define ELP_BSEL_BIT 16
`define ELP_LMAP_BIT 17
// Egress word 1: valid above the tag
`define ELP_EVALID_BIT 16

// Service protection mode encodings
`define ELP_MODE_NONE 2'h0
`define ELP_MODE_UNI 2'h1
`define ELP_MODE_WORK 2'h2
`define ELP_MODE_PROT 2'h3

// Standby drop points
`define ELP_DP_BEFORE_MEP 2'h0
`define ELP_DP_BEFORE_STAT 2'h1
`define ELP_DP_AFTER_STAT 2'h2

`define ELP_FTYPE_MC 2'h3
`define ELP_LIMIT_RST 8'hFF

`endif

/* logic/elp_core.v */
// Linear protection tagging, standby drop, learning key and egress lookup
`timescale 1ns/1ps
// What this block does
// - UNI mode 1 tags frame when protection
// - Mode 2 drops working frames on protection
// - Mode 3 drops protection frames on working
// - Service entry selects its protection group
// - Each network service stores standby drop point
// - Drop point gates MEP and counter visibility
// - Forward type 3 learns on group index
// - Switch-over needs no learned entry flush
// - Learn limit enforced per filtering identifier
// - Egress key: port, flag, service
// - Egress action gives MPLS encapsulation pointer
// - Inner label from action or mapping
// - Egress action gives VLAN tagging
// - Action carries backup encapsulation pointer
// - Flag follows software group state write
// - Backup select picks pointer when flagged
`include "elp_map.vh"

module elp_core #(
	parameter SVC_W = 4,
	parameter GRP_W = 3,
	parameter PORT_W = 2,
	parameter FID_W = 4
) (
	input wire clk,
	input wire resetn,
	// Register port
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_ff,
	// Ingress frames from classifier
	input wire in_valid,
	input wire [SVC_W-1:0] in_svc,
	input wire [PORT_W-1:0] in_src_port,
	input wire in_learn_req,
	output reg out_valid_ff,
	output reg out_protection_active_flag_ff,
	output reg out_discard_ff,
	output reg out_mep_visible_ff,
	output reg out_stat_visible_ff,
	output reg out_learn_ff,
	output reg out_learn_on_mc_ff,
	output reg [7:0] out_learn_key_ff,
	output reg [FID_W-1:0] out_fid_ff,
	// Egress lookup from rewriter
	input wire eg_valid,
	input wire [PORT_W-1:0] eg_port,
	input wire eg_prot_flag,
	input wire [SVC_W-1:0] eg_svc,
	input wire [19:0] eg_map_lse,
	output reg eg_out_valid_ff,
	output reg eg_hit_ff,
	output reg [7:0] eg_encap_ff,
	output reg [15:0] eg_vlan_ff,
	output reg [19:0] eg_lse_ff
);

	localparam NSVC = 1 << SVC_W;
	localparam NGRP = 1 << GRP_W;
	localparam NFID = 1 << FID_W;
	localparam EIX_W = PORT_W + 1 + SVC_W;
	localparam NEGR = 1 << EIX_W;

	// ********************************************
	// Tables
	// ********************************************
	reg [15:0] svc_cfg_ff [0:NSVC-1];
	reg [7:0] svc_mc_ff [0:NSVC-1];
	reg [NGRP-1:0] grp_state_ff;
	reg [7:0] lim_ff [0:NFID-1];
	reg [7:0] cnt_ff [0:NFID-1];
	reg [17:0] eg_act [0:NEGR-1];
	reg [15:0] eg_vlan [0:NEGR-1];
	reg [19:0] eg_lse [0:NEGR-1];
	reg [NEGR-1:0] eg_valid_ff;

	// ********************************************
	// Register decode
	// ********************************************
	wire [1:0] tsel;
	wire svc_word;
	wire [SVC_W-1:0] svc_ix;
	wire [1:0] misc_sel;
	wire [1:0] eg_word;
	wire [EIX_W-1:0] eg_wix;
	wire [GRP_W-1:0] grp_wix;
	wire [FID_W-1:0] fid_wix;

	assign tsel = reg_addr[11:10];
	assign svc_word = reg_addr[`ELP_SVC_WORD_BIT];
	assign svc_ix = reg_addr[SVC_W-1:0];
	assign misc_sel = reg_addr[9:8];
	assign eg_word = reg_addr[9:8];
	assign eg_wix = reg_addr[EIX_W-1:0];
	assign grp_wix = reg_addr[GRP_W-1:0];
	assign fid_wix = reg_addr[FID_W-1:0];

	wire wr_svc;
	wire wr_grp;
	wire wr_lim;
	wire wr_cnt;
	wire wr_egr;

	assign wr_svc = reg_wr && (tsel == `ELP_TSEL_SVC);
	assign wr_grp = reg_wr && (tsel == `ELP_TSEL_MISC) && (misc_sel == `ELP_MISC_SEL_GRP);
	assign wr_lim = reg_wr && (tsel == `ELP_TSEL_MISC) && (misc_sel == `ELP_MISC_SEL_LIM);
	assign wr_cnt = reg_wr && (tsel == `ELP_TSEL_MISC) && (misc_sel == `ELP_MISC_SEL_CNT);
	assign wr_egr = reg_wr && (tsel == `ELP_TSEL_EGR);

	// ********************************************
	// Ingress lookup
	// ********************************************
	wire [15:0] cfg;
	wire [1:0] mode;
	wire [1:0] drop_pt;
	wire [GRP_W-1:0] grp;
	wire [1:0] ftype;
	wire [FID_W-1:0] filtering_identifier;
	wire st_prot;
	wire tag;
	wire drop;
	wire on_mc;
	wire lim_ok;
	wire learn;

	assign cfg = svc_cfg_ff[in_svc];
	assign mode = cfg[`ELP_MODE_LSB+1:`ELP_MODE_LSB];
	assign drop_pt = cfg[`ELP_DROP_LSB+1:`ELP_DROP_LSB];
	assign grp = cfg[`ELP_GRP_LSB+GRP_W-1:`ELP_GRP_LSB];
	assign ftype = cfg[`ELP_FTYPE_LSB+1:`ELP_FTYPE_LSB];
	assign filtering_identifier = cfg[`ELP_FID_LSB+FID_W-1:`ELP_FID_LSB];
	// Live state each frame, so one write moves every sharing service
	assign st_prot = grp_state_ff[grp];
	assign tag = (mode == `ELP_MODE_UNI) && st_prot;
	assign drop = ((mode == `ELP_MODE_WORK) && st_prot) ||
		((mode == `ELP_MODE_PROT) && !st_prot);
	assign on_mc = (ftype == `ELP_FTYPE_MC);
	assign lim_ok = cnt_ff[filtering_identifier] < lim_ff[filtering_identifier];
	assign learn = in_valid && in_learn_req && !drop && lim_ok;

	// ********************************************
	// Configuration writes
	// ********************************************
	integer i;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < NSVC; i = i + 1) begin
				svc_cfg_ff[i] <= 16'h0000;
				svc_mc_ff[i] <= 8'h00;
			end
			grp_state_ff <= {NGRP{1'b0}};
		end else begin
			if (wr_svc && !svc_word) begin
				svc_cfg_ff[svc_ix] <= reg_wdata[15:0];
			end
			if (wr_svc && svc_word) begin
				svc_mc_ff[svc_ix] <= reg_wdata[`ELP_MC_LSB+7:`ELP_MC_LSB];
			end
			if (wr_grp) begin
				grp_state_ff[grp_wix] <= reg_wdata[0];
			end
		end
	end

	// ********************************************
	// Learn limit counters
	// ********************************************
	// A clear and an increment in the same cycle leave the count at one
	genvar g;
	generate
		for (g = 0; g < NFID; g = g + 1) begin : gen_fid
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					lim_ff[g] <= `ELP_LIMIT_RST;
					cnt_ff[g] <= 8'h00;
				end else begin
					if (wr_lim && (fid_wix == g)) begin
						lim_ff[g] <= reg_wdata[7:0];
					end
					if (learn && (filtering_identifier == g)) begin
						if (wr_cnt && (fid_wix == g)) begin
							cnt_ff[g] <= 8'h01;
						end else begin
							cnt_ff[g] <= cnt_ff[g] + 8'h01;
						end
					end else if (wr_cnt && (fid_wix == g)) begin
						cnt_ff[g] <= 8'h00;
					end
				end
			end
		end
	endgenerate

	// ********************************************
	// Egress table
	// ********************************************
	// Contents need no reset; the valid vector guards them
	always @(posedge clk) begin
		if (wr_egr && (eg_word == `ELP_EGR_WORD_ACT)) begin
			eg_act[eg_wix] <= reg_wdata[17:0];
		end
		if (wr_egr && (eg_word == `ELP_EGR_WORD_VLAN)) begin
			eg_vlan[eg_wix] <= reg_wdata[15:0];
		end
		if (wr_egr && (eg_word == `ELP_EGR_WORD_LSE)) begin
			eg_lse[eg_wix] <= reg_wdata[19:0];
		end
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eg_valid_ff <= {NEGR{1'b0}};
		end else if (wr_egr && (eg_word == `ELP_EGR_WORD_VLAN)) begin
			eg_valid_ff[eg_wix] <= reg_wdata[`ELP_EVALID_BIT];
		end
	end

	// ********************************************
	// Egress lookup
	// ********************************************
	wire [EIX_W-1:0] eix;
	wire [17:0] act;
	wire use_backup;
	wire [7:0] nxt_encap;
	wire [19:0] nxt_lse;

	// Port and flag in the key split working from protection
	assign eix = {eg_port, eg_prot_flag, eg_svc};
	assign act = eg_act[eix];
	assign use_backup = eg_prot_flag && act[`ELP_BSEL_BIT];
	assign nxt_encap = use_backup ? act[`ELP_BENC_LSB+7:`ELP_BENC_LSB] :
		act[`ELP_ENC_LSB+7:`ELP_ENC_LSB];
	assign nxt_lse = act[`ELP_LMAP_BIT] ? eg_map_lse : eg_lse[eix];

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eg_out_valid_ff <= 1'b0;
			eg_hit_ff <= 1'b0;
			eg_encap_ff <= 8'h00;
			eg_vlan_ff <= 16'h0000;
			eg_lse_ff <= 20'h00000;
		end else begin
			eg_out_valid_ff <= eg_valid;
			if (eg_valid) begin
				eg_hit_ff <= eg_valid_ff[eix];
				if (eg_valid_ff[eix]) begin
					eg_encap_ff <= nxt_encap;
					eg_vlan_ff <= eg_vlan[eix];
					eg_lse_ff <= nxt_lse;
				end else begin
					eg_encap_ff <= 8'h00;
					eg_vlan_ff <= 16'h0000;
					eg_lse_ff <= 20'h00000;
				end
			end
		end
	end

	// ********************************************
	// Ingress result
	// ********************************************
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_valid_ff <= 1'b0;
			out_protection_active_flag_ff <= 1'b0;
			out_discard_ff <= 1'b0;
			out_mep_visible_ff <= 1'b0;
			out_stat_visible_ff <= 1'b0;
			out_learn_ff <= 1'b0;
			out_learn_on_mc_ff <= 1'b0;
			out_learn_key_ff <= 8'h00;
			out_fid_ff <= {FID_W{1'b0}};
		end else begin
			out_valid_ff <= in_valid;
			out_learn_ff <= learn;
			if (in_valid) begin
				out_protection_active_flag_ff <= tag;
				out_discard_ff <= drop;
				// Later drop point lets more stages see the frame
				out_mep_visible_ff <= !drop || (drop_pt != `ELP_DP_BEFORE_MEP);
				out_stat_visible_ff <= !drop || (drop_pt == `ELP_DP_AFTER_STAT);
				out_learn_on_mc_ff <= on_mc;
				// Group key never names a port, so no flush on switch-over
				out_learn_key_ff <= on_mc ? svc_mc_ff[in_svc] :
					{{(8-PORT_W){1'b0}}, in_src_port};
				out_fid_ff <= filtering_identifier;
			end
		end
	end

	// ********************************************
	// Register read
	// ********************************************
	reg [31:0] nxt_rdata;

	always @* begin
		nxt_rdata = 32'h00000000;
		case (tsel)
			`ELP_TSEL_SVC: begin
				if (svc_word) begin
					nxt_rdata = {24'h000000, svc_mc_ff[svc_ix]};
				end else begin
					nxt_rdata = {16'h0000, svc_cfg_ff[svc_ix]};
				end
			end
			`ELP_TSEL_MISC: begin
				case (misc_sel)
					`ELP_MISC_SEL_GRP: nxt_rdata = {31'h00000000, grp_state_ff[grp_wix]};
					`ELP_MISC_SEL_LIM: nxt_rdata = {24'h000000, lim_ff[fid_wix]};
					`ELP_MISC_SEL_CNT: nxt_rdata = {24'h000000, cnt_ff[fid_wix]};
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			`ELP_TSEL_EGR: begin
				case (eg_word)
					`ELP_EGR_WORD_ACT: nxt_rdata = {14'h0000, eg_act[eg_wix]};
					`ELP_EGR_WORD_VLAN: nxt_rdata = {15'h0000, eg_valid_ff[eg_wix],
						eg_vlan[eg_wix]};
					`ELP_EGR_WORD_LSE: nxt_rdata = {12'h000, eg_lse[eg_wix]};
					default: nxt_rdata = 32'h00000000;
				endcase
			end
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata_ff <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_ff <= nxt_rdata;
		end else begin
			reg_rdata_ff <= 32'h00000000;
		end
	end

endmodule

/* verification/elp_core_sva.sv */
// Port checker for the linear protection block
`timescale 1ns/1ps
module elp_core_sva (
	input wire clk,
	input wire resetn,
	input wire reg_rd,
	input wire [31:0] reg_rdata_ff,
	input wire in_valid,
	input wire out_valid_ff,
	input wire out_discard_ff,
	input wire out_mep_visible_ff,
	input wire out_stat_visible_ff,
	input wire out_learn_ff,
	input wire eg_valid,
	input wire eg_out_valid_ff,
	input wire eg_hit_ff,
	input wire [7:0] eg_encap_ff,
	input wire [15:0] eg_vlan_ff
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	frame_lat_a: assert property (in_valid |=> out_valid_ff)
		else $error("frame result missing");
	idle_quiet_a: assert property ($rose(out_valid_ff) |-> $past(in_valid))
		else $error("frame result without frame");
	egr_lat_a: assert property (eg_valid |=> eg_out_valid_ff)
		else $error("lookup result missing");
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata_ff == 32'h0)
		else $error("read data outside read slot");
	drop_nolearn_a: assert property (out_valid_ff && out_discard_ff |->
		!out_learn_ff)
		else $error("discarded frame learned");
	learn_valid_a: assert property (out_learn_ff |-> out_valid_ff)
		else $error("learn without frame");
	pass_visible_a: assert property (out_valid_ff && !out_discard_ff |->
		out_mep_visible_ff && out_stat_visible_ff)
		else $error("kept frame hidden");
	drop_order_a: assert property (out_valid_ff && out_stat_visible_ff |->
		out_mep_visible_ff)
		else $error("counters see frame that endpoint misses");
	miss_zero_a: assert property (eg_out_valid_ff && !eg_hit_ff |->
		{eg_encap_ff, eg_vlan_ff} == 24'h0)
		else $error("miss carries action");
	cover property (out_valid_ff && out_discard_ff);
	cover property (out_learn_ff);
	cover property (eg_out_valid_ff && eg_hit_ff);
endmodule
bind elp_core elp_core_sva u_sva (.*);

/* verification/elp_peer.sv */
// Classifier and rewriter stand-in issuing frames and lookups
`timescale 1ns/1ps
module elp_peer (
	input wire clk,
	output logic in_valid,
	output logic [3:0] in_svc,
	output logic [1:0] in_src_port,
	output logic in_learn_req,
	output logic eg_valid,
	output logic [1:0] eg_port,
	output logic eg_prot_flag,
	output logic [3:0] eg_svc,
	output logic [19:0] eg_map_lse
);
	// ****************
	// Requests
	// ****************
	initial begin
		{in_valid, in_svc, in_src_port, in_learn_req} = 8'h0;
		{eg_valid, eg_port, eg_prot_flag, eg_svc, eg_map_lse} = 28'h0;
	end
	// Idle data except the source port is scrambled so nothing leans on a stale key
	task frame(input logic [3:0] s, input logic l);
		@(posedge clk);
		in_valid <= 1'b1;
		in_svc <= s;
		in_src_port <= 2'h2;
		in_learn_req <= l;
		@(posedge clk);
		in_valid <= 1'b0;
		in_svc <= ~s;
		in_learn_req <= ~l;
		#1;
	endtask
	task lookup(input logic [1:0] p, input logic f, input logic [3:0] s, input logic [19:0] m);
		@(posedge clk);
		eg_valid <= 1'b1;
		{eg_port, eg_prot_flag, eg_svc, eg_map_lse} <= {p, f, s, m};
		@(posedge clk);
		eg_valid <= 1'b0;
		{eg_port, eg_prot_flag, eg_svc, eg_map_lse} <= ~{p, f, s, m};
		#1;
	endtask
endmodule

/* verification/elp_core_tb.sv */
// Self-checking bench for the linear protection block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module elp_core_tb;
	logic clk, resetn, reg_wr, reg_rd, in_valid, in_learn_req, eg_valid, eg_prot_flag;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_ff;
	logic [3:0] in_svc, eg_svc, out_fid_ff;
	logic [1:0] in_src_port, eg_port;
	logic [19:0] eg_map_lse, eg_lse_ff;
	logic out_valid_ff, out_protection_active_flag_ff, out_discard_ff, out_mep_visible_ff;
	logic out_stat_visible_ff, out_learn_ff, out_learn_on_mc_ff, eg_out_valid_ff, eg_hit_ff;
	logic [7:0] out_learn_key_ff, eg_encap_ff;
	logic [15:0] eg_vlan_ff;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	elp_core u_dut (.*);
	elp_peer u_peer (.*);
	// ****************
	// Clock, bus tasks and closing
	// ****************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata_ff, e)
	endtask
	task complete_run;
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Run takes about a hundred cycles; ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			complete_run;
		end
	end
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 47'h0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd(12'h402, 32'h0);
		rd(12'h505, 32'hFF);
		rd(12'hC00, 32'h0);
		wr(12'h001, 32'h21);
		wr(12'h002, 32'h21);
		wr(12'h003, 32'h26);
		wr(12'h004, 32'h5323);
		wr(12'h014, 32'h7A);
		wr(12'h505, 32'h1);
		wr(12'h006, 32'h3B);
		u_peer.frame(4'h1, 1'b0);
		`CHK({out_protection_active_flag_ff, out_discard_ff}, 2'b00)
		u_peer.frame(4'h1, 1'b1);
		`CHK({out_learn_ff, out_learn_on_mc_ff, out_learn_key_ff, out_fid_ff}, 14'h2020)
		u_peer.frame(4'h3, 1'b0);
		`CHK(out_discard_ff, 1'b0)
		u_peer.frame(4'h4, 1'b1);
		`CHK(out_discard_ff, 1'b1)
		`CHK({out_mep_visible_ff, out_stat_visible_ff, out_learn_ff}, 3'b000)
		u_peer.frame(4'h6, 1'b0);
		`CHK({out_discard_ff, out_mep_visible_ff, out_stat_visible_ff}, 3'b111)
		wr(12'h402, 32'h1);
		rd(12'h402, 32'h1);
		u_peer.frame(4'h2, 1'b0);
		`CHK(out_protection_active_flag_ff, 1'b1)
		u_peer.frame(4'h1, 1'b0);
		`CHK(out_protection_active_flag_ff, 1'b1)
		u_peer.frame(4'h5, 1'b0);
		`CHK({out_protection_active_flag_ff, out_discard_ff}, 2'b00)
		u_peer.frame(4'h6, 1'b0);
		`CHK(out_discard_ff, 1'b1)
		u_peer.frame(4'h3, 1'b0);
		`CHK(out_discard_ff, 1'b1)
		`CHK({out_mep_visible_ff, out_stat_visible_ff}, 2'b10)
		u_peer.frame(4'h4, 1'b1);
		`CHK({out_learn_ff, out_learn_on_mc_ff, out_learn_key_ff, out_fid_ff}, 14'h37A5)
		u_peer.frame(4'h4, 1'b1);
		`CHK(out_learn_ff, 1'b0)
		rd(12'h605, 32'h1);
		wr(12'h605, 32'h0);
		rd(12'h605, 32'h0);
		u_peer.frame(4'h4, 1'b1);
		`CHK(out_learn_ff, 1'b1)
		wr(12'h833, 32'h12211);
		wr(12'h933, 32'h1ABCD);
		wr(12'hA33, 32'h12345);
		wr(12'h823, 32'h12211);
		wr(12'h923, 32'h10005);
		u_peer.lookup(2'h1, 1'b1, 4'h3, 20'h0F0F0);
		`CHK({eg_hit_ff, eg_encap_ff}, 9'h122)
		`CHK({eg_vlan_ff, eg_lse_ff}, 36'hABCD_12345)
		u_peer.lookup(2'h1, 1'b0, 4'h3, 20'h0);
		`CHK({eg_hit_ff, eg_encap_ff, eg_vlan_ff}, 25'h1_11_0005)
		wr(12'h833, 32'h02211);
		u_peer.lookup(2'h1, 1'b1, 4'h3, 20'h0);
		`CHK(eg_encap_ff, 8'h11)
		wr(12'h823, 32'h22211);
		u_peer.lookup(2'h1, 1'b0, 4'h3, 20'h0F0F0);
		`CHK(eg_lse_ff, 20'h0F0F0)
		u_peer.lookup(2'h0, 1'b1, 4'h3, 20'h0);
		`CHK({eg_hit_ff, eg_encap_ff}, 9'h0)
		`CHK({eg_vlan_ff, eg_lse_ff}, 36'h0)
		// Mid-run reset must bring back working state and default limits
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd(12'h402, 32'h0);
		rd(12'h505, 32'hFF);
		u_peer.frame(4'h2, 1'b0);
		`CHK({out_valid_ff, out_protection_active_flag_ff}, 2'b10)
		complete_run;
	end
endmodule
